// >>> acmr_responder.v
// Purpose: marker responder logic inside one active cable plug
// Assumes: one request pulse per decoded message; replies sent by phy layer
// Notes: one clock, synchronous request inputs
//
// Notes on behaviour
// - answer identity discovery and status queries addressed to SOP'
// - answer SOP'' status when far-plug controller bit set in descriptor
// - isolated cable: SOP'' means plug far from the exchange initiator
// - identity reply carries active cable descriptor objects
// - reply uses revision 2 or 3 per negotiated revision
// - implements revision 3 structured vendor message handling
// - two-repeater cable provides both SOP' and SOP'' responders
// - single body repeater: SOP' responder only, SOP'' only when isolated
// - isolated cable plug presents itself as a sink on first connect
// - isolated cable uses revision 3 to set one DFP, one UFP
// - isolated cable has a marker responder at each plug
// - isolated cable supports only a subset of messages
// - isolated cable: no end to end relaying until connection active, configured and role set
`timescale 1ns/100ps
`include "acmr_consts.vh"

module acmr_responder #(
	parameter VDO_RESET = 32'h0000_0000,
	parameter TWO_REPEATERS = 1'b1
) (
	// clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// static cable configuration
	input wire isolated_i,
	input wire [`ACMR_VDO_W-1:0] vdo_i,
	input wire [`ACMR_VDO_W-1:0] status_i,
	// incoming decoded request
	input wire req_valid_i,
	input wire [1:0] req_sop_i,
	input wire [1:0] req_kind_i,
	input wire req_structured_i,
	input wire [1:0] req_rev_i,
	input wire req_is_role_set_i,
	input wire req_role_dfp_i,
	// link state
	input wire attach_i,
	input wire link_active_i,
	input wire cfg_done_i,
	// reply
	output wire rsp_valid_o,
	output reg [1:0] rsp_kind_o,
	output reg [1:0] rsp_sop_o,
	output reg [1:0] rsp_rev_o,
	output reg [`ACMR_VDO_W-1:0] rsp_data_o,
	// plug state
	output reg [1:0] role_o,
	output wire relay_en_o,
	output wire local_only_o
);

	// reply and descriptor registers
	reg rsp_pend_ff;
	reg [`ACMR_VDO_W-1:0] vdo_ff;
	// next values of the clocked state
	reg nxt_rsp_pend;
	reg [1:0] nxt_rsp_kind;
	reg [1:0] nxt_rsp_sop;
	reg [1:0] nxt_rsp_rev;
	reg [`ACMR_VDO_W-1:0] nxt_rsp_data;
	reg [1:0] nxt_role;
	// request decode
	wire far_flag;
	wire far_present;
	wire sop_hit;
	wire sop_p_hit;
	wire sop_pp_hit;
	wire ident_kind;
	wire status_kind;
	wire ident_ok;
	wire status_ok;
	wire role_set;
	wire role_ok;
	wire link_ready;

	// packet type matches a code
	function sop_is;
		input [1:0] sop;
		input [1:0] code;
		begin
			sop_is = (sop == code);
		end
	endfunction

	// request kind matches a code
	function kind_is;
		input [1:0] kind;
		input [1:0] code;
		begin
			kind_is = (kind == code);
		end
	endfunction

	// plug has left its initial sink state
	function role_taken;
		input [1:0] role;
		begin
			role_taken = (role != `ACMR_ROLE_SINK);
		end
	endfunction

	// unknown revision codes answer as rev 3
	function [1:0] pick_rev;
		input [1:0] rev;
		begin
			if (rev == `ACMR_REV2)
				pick_rev = `ACMR_REV2;
			else
				pick_rev = `ACMR_REV3;
		end
	endfunction

	// far flag only counts when a far responder is built in
	assign far_flag = vdo_ff[`ACMR_VDO_FAR_BIT];
	assign far_present = far_flag &
		(TWO_REPEATERS | isolated_i);
	assign sop_hit = req_valid_i & sop_is(req_sop_i, `ACMR_SOP);
	assign sop_p_hit = req_valid_i & sop_is(req_sop_i, `ACMR_SOP_P);
	// isolated: SOP'' is the plug far from the initiator
	assign sop_pp_hit = req_valid_i & sop_is(req_sop_i, `ACMR_SOP_PP) &
		far_present;
	assign ident_kind = kind_is(req_kind_i, `ACMR_REQ_IDENT);
	assign status_kind = kind_is(req_kind_i, `ACMR_REQ_STATUS);
	// identity only on SOP'
	assign ident_ok = sop_p_hit & ident_kind & req_structured_i;
	assign status_ok = (sop_p_hit | sop_pp_hit) & status_kind;
	// role set only via rev 3 on SOP from the attached port
	assign role_set = sop_hit & isolated_i & req_is_role_set_i;
	assign role_ok = role_set & (req_rev_i == `ACMR_REV3) &
		~role_taken(role_o);
	assign link_ready = link_active_i & cfg_done_i & role_taken(role_o);

	assign rsp_valid_o = rsp_pend_ff;
	assign relay_en_o = ~isolated_i | link_ready;
	assign local_only_o = ~relay_en_o;

	// reply selection
	always @* begin
		nxt_rsp_pend = 1'b0;
		nxt_rsp_kind = rsp_kind_o;
		nxt_rsp_sop = rsp_sop_o;
		nxt_rsp_rev = rsp_rev_o;
		nxt_rsp_data = rsp_data_o;
		if (ident_ok) begin
			// identity reply carries the captured descriptor
			nxt_rsp_pend = 1'b1;
			nxt_rsp_kind = `ACMR_RSP_IDENT;
			nxt_rsp_sop = req_sop_i;
			nxt_rsp_rev = pick_rev(req_rev_i);
			nxt_rsp_data = vdo_ff;
		end else if (status_ok) begin
			// status reply returns the live status word
			nxt_rsp_pend = 1'b1;
			nxt_rsp_kind = `ACMR_RSP_STATUS;
			nxt_rsp_sop = req_sop_i;
			nxt_rsp_rev = pick_rev(req_rev_i);
			nxt_rsp_data = status_i;
		end else begin
			// stay silent, keep the last reply fields
			nxt_rsp_pend = 1'b0;
		end
	end

	// plug role
	always @* begin
		nxt_role = role_o;
		if (!attach_i) begin
			nxt_role = `ACMR_ROLE_SINK;
		end else if (role_ok) begin
			if (req_role_dfp_i) begin
				nxt_role = `ACMR_ROLE_DFP;
			end else begin
				nxt_role = `ACMR_ROLE_UFP;
			end
		end
	end

	// descriptor capture
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			vdo_ff <= VDO_RESET;
		end else if (ce_i) begin
			vdo_ff <= vdo_i;
		end
	end

	// reply registers
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rsp_pend_ff <= 1'b0;
			rsp_kind_o <= `ACMR_RSP_NONE;
			rsp_sop_o <= `ACMR_SOP;
			rsp_rev_o <= `ACMR_REV3;
			rsp_data_o <= {`ACMR_VDO_W{1'b0}};
		end else if (ce_i) begin
			rsp_pend_ff <= nxt_rsp_pend;
			rsp_kind_o <= nxt_rsp_kind;
			rsp_sop_o <= nxt_rsp_sop;
			rsp_rev_o <= nxt_rsp_rev;
			rsp_data_o <= nxt_rsp_data;
		end
	end

	// plug role register
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			role_o <= `ACMR_ROLE_SINK;
		end else if (ce_i) begin
			role_o <= nxt_role;
		end
	end

endmodule

// >>> acmr_consts.vh
// Purpose: constants for the cable marker responder
// Assumes: decoded message headers arrive from an upstream phy/protocol layer
// Notes: packet type and message codes are local encodings
`ifndef ACMR_CONSTS_VH
`define ACMR_CONSTS_VH

// packet types seen by the plug
`define ACMR_SOP 2'h0
`define ACMR_SOP_P 2'h1
`define ACMR_SOP_PP 2'h2

// request kinds
`define ACMR_REQ_OTHER 2'h0
`define ACMR_REQ_IDENT 2'h1
`define ACMR_REQ_STATUS 2'h2

// reply kinds
`define ACMR_RSP_NONE 2'h0
`define ACMR_RSP_IDENT 2'h1
`define ACMR_RSP_STATUS 2'h2

// protocol revisions
`define ACMR_REV2 2'h1
`define ACMR_REV3 2'h2

// data role of this plug
`define ACMR_ROLE_SINK 2'h0
`define ACMR_ROLE_DFP 2'h1
`define ACMR_ROLE_UFP 2'h2

// descriptor bit: far-plug controller present
`define ACMR_VDO_FAR_BIT 5'h1e
`define ACMR_VDO_W 32

`endif

// >>> acmr_asserts.sv
// Purpose: reply, role and relay checks; Assumes: dut ports; Notes: bound in bench
`timescale 1ns/100ps
module acmr_asserts(input wire clk_i, rst_i, ce_i, isolated_i,
	req_valid_i, req_structured_i, req_is_role_set_i, req_role_dfp_i,
	attach_i, link_active_i, cfg_done_i, rsp_valid_o, relay_en_o,
	local_only_o, input wire [1:0] req_sop_i, req_kind_i, req_rev_i,
	input wire [1:0] rsp_kind_o, rsp_rev_o, role_o,
	input wire [31:0] vdo_i, status_i, rsp_data_o);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire tk = ce_i && req_valid_i;
sequence s_far;
	tk && req_sop_i == 2'h2 && req_kind_i == 2'h2 && vdo_i[30];
endsequence
a_ident_reply: assert property (tk && req_sop_i == 2'h1 && req_kind_i == 2'h1
	&& req_structured_i |=> rsp_valid_o && rsp_kind_o == 2'h1) else $error("ident");
a_status_reply: assert property (tk && req_sop_i == 2'h1 && req_kind_i == 2'h2
	|=> rsp_valid_o && rsp_data_o == $past(status_i)) else $error("status");
a_far_status: assert property (s_far ##0 $past(vdo_i[30] && ce_i && !rst_i)
	|=> rsp_valid_o && rsp_kind_o == 2'h2) else $error("far status");
a_sop_silent: assert property (tk && req_sop_i == 2'h0 |=> !rsp_valid_o)
	else $error("sop reply");
a_rev_follow: assert property (rsp_valid_o |-> rsp_rev_o ==
	($past(req_rev_i) == 2'h1 ? 2'h1 : 2'h2)) else $error("rev");
a_role_setup: assert property (tk && req_is_role_set_i && attach_i
	&& isolated_i && role_o == 2'h0 && req_rev_i == 2'h2
	&& req_sop_i == 2'h0 |=>
	role_o == ($past(req_role_dfp_i) ? 2'h1 : 2'h2)) else $error("role");
a_sink_detach: assert property (ce_i && !attach_i |=> role_o == 2'h0)
	else $error("sink");
a_relay_gate: assert property (local_only_o != relay_en_o && relay_en_o ==
	(!isolated_i || link_active_i && cfg_done_i && role_o != 2'h0))
	else $error("relay");
endmodule

// >>> acmr_partner.sv
// Purpose: port controller; Assumes: one clock; Notes: pulse requests
`timescale 1ns/100ps
module acmr_partner(input wire clk_i, output reg req_valid_i = 0,
	output reg req_structured_i, req_is_role_set_i, req_role_dfp_i,
	output reg [1:0] req_sop_i, req_kind_i, req_rev_i);
task send(input [1:0] s, k, r, input st, rs, d);
	begin
		@(posedge clk_i) #1 {req_sop_i, req_kind_i, req_rev_i} = {s, k, r};
		{req_structured_i, req_is_role_set_i, req_role_dfp_i} = {st, rs, d};
		req_valid_i = 1'h1;
		@(posedge clk_i) #1 req_valid_i = 1'h0;
		{req_sop_i, req_kind_i} = ~{s, k};
	end
endtask
endmodule

// >>> active_cable_marker_responder_test.sv
// Purpose: scenarios; Assumes: partner drives requests; Notes: ce high except in t_freeze
`timescale 1ns/100ps
module active_cable_marker_responder_test;
reg clk_i = 0, rst_i = 1, ce_i = 1, isolated_i = 0, attach_i = 0;
reg link_active_i = 0, cfg_done_i = 0;
reg [31:0] vdo_i = 32'h1234, status_i = 32'h5a5a;
wire req_valid_i, req_structured_i, req_is_role_set_i, req_role_dfp_i;
wire [1:0] req_sop_i, req_kind_i, req_rev_i, rsp_kind_o, rsp_sop_o;
wire [1:0] rsp_rev_o, role_o;
wire [31:0] rsp_data_o;
wire rsp_valid_o, relay_en_o, local_only_o;
integer err_count = 0, total_checks = 0, cyc = 0;
always #25 clk_i = ~clk_i;
acmr_partner p(.*);
acmr_responder dut(.*);
task chk(input string n, input [31:0] s, e);
	begin
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	end
endtask
task end_sim;
	begin
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
endtask
always @(posedge clk_i) if (++cyc > 999) begin
	err_count++;
	end_sim;
end
task t_ident;
	begin
		p.send(2'h1, 2'h1, 2'h1, 1, 0, 0);
		chk("id", {rsp_valid_o, rsp_kind_o, rsp_rev_o}, 5'h15);
		chk("idv", rsp_data_o, 32'h1234);
		chk("rel", {relay_en_o, local_only_o}, 2'h2);
		p.send(2'h2, 2'h1, 2'h2, 1, 0, 0);
		chk("idf", rsp_valid_o, 0);
		p.send(2'h2, 2'h2, 2'h2, 1, 0, 0);
		chk("stn", rsp_valid_o, 0);
		p.send(2'h0, 2'h2, 2'h2, 1, 0, 0);
		chk("sop", rsp_valid_o, 0);
	end
endtask
task t_status;
	begin
		vdo_i = 32'h4000_0000;
		p.send(2'h1, 2'h2, 2'h2, 1, 0, 0);
		chk("st", {rsp_valid_o, rsp_kind_o, rsp_rev_o}, 5'h1a);
		chk("std", rsp_data_o, 32'h5a5a);
		p.send(2'h2, 2'h2, 2'h2, 1, 0, 0);
		chk("stf", {rsp_valid_o, rsp_kind_o, rsp_sop_o}, 5'h1a);
		p.send(2'h1, 2'h2, 2'h3, 1, 0, 0);
		chk("st3", {rsp_valid_o, rsp_rev_o}, 3'h6);
	end
endtask
task t_role;
	begin
		isolated_i = 1;
		attach_i = 1;
		#1 chk("loc", {relay_en_o, local_only_o, role_o}, 4'h4);
		p.send(2'h0, 2'h0, 2'h2, 0, 1, 1);
		chk("dfp", role_o, 1);
		{link_active_i, cfg_done_i} = 2'h3;
		#1 chk("rly", {relay_en_o, local_only_o}, 2'h2);
		@(posedge clk_i) #1 attach_i = 0;
		@(posedge clk_i) #1 chk("snk", role_o, 0);
		attach_i = 1;
		p.send(2'h0, 2'h0, 2'h2, 0, 1, 0);
		chk("ufp", role_o, 2);
	end
endtask
task t_freeze;
	begin
		ce_i = 0;
		attach_i = 0;
		p.send(2'h1, 2'h2, 2'h1, 1, 0, 0);
		chk("frz", {rsp_valid_o, role_o}, 3'h2);
		ce_i = 1;
		@(posedge clk_i) #1 chk("thaw", role_o, 0);
		attach_i = 1;
		p.send(2'h1, 2'h1, 2'h2, 1, 0, 0);
		chk("pre", rsp_valid_o, 1);
		rst_i = 1;
		@(posedge clk_i) #1 chk("rst", {rsp_valid_o, rsp_kind_o, rsp_rev_o, role_o}, 7'h08);
		chk("rsd", rsp_data_o, 0);
		rst_i = 0;
		p.send(2'h1, 2'h1, 2'h2, 1, 0, 0);
		chk("rid", rsp_data_o, 32'h4000_0000);
	end
endtask
initial begin
	repeat (16) @(posedge clk_i);
	#1 rst_i = 0;
	t_ident;
	t_status;
	t_role;
	t_freeze;
	end_sim;
end
endmodule
bind acmr_responder acmr_asserts chk_i(.*);
